// ---- design/pmcv_phy_mii_control_view.sv ----
// top: partner ability and port-2 basic control registers with phy steering
//
// The strobed register port was decided locally.
`default_nettype none
module pmcv_phy_mii_control_view (
  input  wire logic                    clk,               // 25 MHz system clock
  input  wire logic                    reset,             // async, active high
  input  wire logic [11:0]             regAddr,           // byte address
  input  wire logic [15:0]             regWrData,         // write data
  input  wire logic                    regWrite,          // write strobe
  input  wire logic                    regRead,           // read strobe
  output logic      [15:0]             regRdData,         // read data, one cycle later
  input  wire logic [4:0]              port1StatusRaw,    // port-1 status bits 4..0 from phy
  input  wire logic                    anRestartDone,     // phy took the restart request
  output pmcv_pkg::pmcv_phy_ctl_s      phyCtl,            // steering to port-2 phy
  output logic                         loopPort1Pairs,    // port-1 pairs looped at port 2
  output logic                         port2Speed100,     // forced speed, 1 = 100
  output logic                         port2FullDuplex,   // duplex when forced or failed
  output logic                         port2TxEnable      // transmitter on
);
  // all state in one packed struct
  typedef struct packed {
    logic [15:0]             rdData;      // read answer
    logic [4:0]              partnerSeen; // captured partner ability from status
    pmcv_pkg::pmcv_phy_ctl_s ctl;         // control bits
    logic                    loopOut;     // loopback request
    logic                    speedOut;    // forced speed
    logic                    duplexOut;   // duplex choice
    logic                    txEnOut;     // transmitter enable
  } pmcv_top_s;

  pmcv_top_s   state;        // registered state
  pmcv_top_s   next_state;   // next value
  logic [4:0]  statusSync;   // status bits after the synchroniser
  logic [15:0] partnerWord;  // assembled partner register
  logic [15:0] controlWord;  // assembled control register
  logic [15:0] ctlMerged;    // control after a write

  // phy status arrives from the analogue side, so settle it first
  pmcv_sync #(
    .WIDTH (5)
  ) uStatusSync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (port1StatusRaw),
    .syncOut (statusSync)
  );

  // partner ability: read-only image of the status bits
  always_comb begin
    partnerWord = pmcv_pkg::PMCV_PARTNER_CONST;
    partnerWord[pmcv_pkg::PMCV_LP_PAUSE] = state.partnerSeen[pmcv_pkg::PMCV_ST_PAUSE];
    partnerWord[pmcv_pkg::PMCV_LP_100FD] = state.partnerSeen[3];
    partnerWord[pmcv_pkg::PMCV_LP_100HD] = state.partnerSeen[2];
    partnerWord[pmcv_pkg::PMCV_LP_10FD]  = state.partnerSeen[1];
    partnerWord[pmcv_pkg::PMCV_LP_10HD]  = state.partnerSeen[0];
  end

  // control register image; unsupported bits stay zero
  always_comb begin
    controlWord = 16'h0000;
    controlWord[pmcv_pkg::PMCV_CT_LOOP]    = state.ctl.farLoop;
    controlWord[pmcv_pkg::PMCV_CT_F100]    = state.ctl.force100;
    controlWord[pmcv_pkg::PMCV_CT_ANEN]    = state.ctl.anEnable;
    controlWord[pmcv_pkg::PMCV_CT_PDOWN]   = state.ctl.powerDown;
    controlWord[pmcv_pkg::PMCV_CT_RESTART] = state.ctl.anRestart;
    controlWord[pmcv_pkg::PMCV_CT_FDUP]    = state.ctl.fullDuplex;
    controlWord[pmcv_pkg::PMCV_CT_XALG]    = state.ctl.xoverAlgo;
    controlWord[pmcv_pkg::PMCV_CT_FXOVER]  = state.ctl.forceCross;
    controlWord[pmcv_pkg::PMCV_CT_NOXOVER] = state.ctl.xoverOff;
    controlWord[pmcv_pkg::PMCV_CT_TXOFF]   = state.ctl.txDisable;
    // a write replaces only the writable bits
    ctlMerged = (controlWord & ~pmcv_pkg::PMCV_CT_WMASK)
              | (regWrData & pmcv_pkg::PMCV_CT_WMASK);
  end

  // next-state logic: bus, self-clearing restart, derived outputs
  always_comb begin
    next_state = state;
    next_state.partnerSeen = statusSync;
    // restart clears once the phy has taken it
    if (anRestartDone) begin
      next_state.ctl.anRestart = 1'b0;
    end
    // register write
    if (regWrite && regAddr == pmcv_pkg::PMCV_OFS_CONTROL) begin
      next_state.ctl.farLoop    = ctlMerged[pmcv_pkg::PMCV_CT_LOOP];
      next_state.ctl.force100   = ctlMerged[pmcv_pkg::PMCV_CT_F100];
      next_state.ctl.anEnable   = ctlMerged[pmcv_pkg::PMCV_CT_ANEN];
      next_state.ctl.powerDown  = ctlMerged[pmcv_pkg::PMCV_CT_PDOWN];
      next_state.ctl.fullDuplex = ctlMerged[pmcv_pkg::PMCV_CT_FDUP];
      next_state.ctl.xoverAlgo  = ctlMerged[pmcv_pkg::PMCV_CT_XALG];
      next_state.ctl.forceCross = ctlMerged[pmcv_pkg::PMCV_CT_FXOVER];
      next_state.ctl.xoverOff   = ctlMerged[pmcv_pkg::PMCV_CT_NOXOVER];
      next_state.ctl.txDisable  = ctlMerged[pmcv_pkg::PMCV_CT_TXOFF];
      // a written one sets restart and beats the done clear; zero leaves it
      if (ctlMerged[pmcv_pkg::PMCV_CT_RESTART]) begin
        next_state.ctl.anRestart = 1'b1;
      end
    end
    // read answer: partner read-only, writes to it ignored
    if (regRead) begin
      case (regAddr)
        pmcv_pkg::PMCV_OFS_PARTNER: next_state.rdData = partnerWord;
        pmcv_pkg::PMCV_OFS_CONTROL: next_state.rdData = controlWord;
        default:                    next_state.rdData = 16'h0000;            // unmapped
      endcase
    end else begin
      next_state.rdData = 16'h0000;                                           // only valid one cycle
    end
    // derived steering, registered so outputs come from flops
    next_state.loopOut   = next_state.ctl.farLoop;
    next_state.speedOut  = next_state.ctl.force100;
    // forced duplex used when negotiation is off; phy also uses it on failure
    next_state.duplexOut = next_state.ctl.fullDuplex;
    // powered-down phy does not transmit either
    next_state.txEnOut   = ~next_state.ctl.txDisable & ~next_state.ctl.powerDown;
  end

  // state registers with documented reset values
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state                <= '0;
      state.ctl.force100   <= 1'b1;
      state.ctl.anEnable   <= 1'b1;
      state.ctl.fullDuplex <= 1'b1;
      state.ctl.xoverAlgo  <= 1'b1;
      state.speedOut       <= 1'b1;
      state.duplexOut      <= 1'b1;
      state.txEnOut        <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flops
  assign regRdData       = state.rdData;
  assign phyCtl          = state.ctl;
  assign loopPort1Pairs  = state.loopOut;
  assign port2Speed100   = state.speedOut;
  assign port2FullDuplex = state.duplexOut;
  assign port2TxEnable   = state.txEnOut;
endmodule
`default_nettype wire

// ---- design/pmcv_pkg.sv ----
// package: offsets, field positions, reset values and carriers for the phy control view
`default_nettype none
package pmcv_pkg;
  // register byte offsets
  localparam logic [11:0] PMCV_OFS_PARTNER = 12'h056;
  localparam logic [11:0] PMCV_OFS_CONTROL = 12'h058;
  // partner ability field positions
  localparam int PMCV_LP_PAUSE  = 10;
  localparam int PMCV_LP_100FD  = 8;
  localparam int PMCV_LP_100HD  = 7;
  localparam int PMCV_LP_10FD   = 6;
  localparam int PMCV_LP_10HD   = 5;
  // status source bit positions
  localparam int PMCV_ST_PAUSE  = 4;
  // low field of partner ability reads constant one
  localparam logic [15:0] PMCV_PARTNER_CONST = 16'h0001;
  // control field positions
  localparam int PMCV_CT_LOOP    = 14;
  localparam int PMCV_CT_F100    = 13;
  localparam int PMCV_CT_ANEN    = 12;
  localparam int PMCV_CT_PDOWN   = 11;
  localparam int PMCV_CT_RESTART = 9;
  localparam int PMCV_CT_FDUP    = 8;
  localparam int PMCV_CT_XALG    = 5;
  localparam int PMCV_CT_FXOVER  = 4;
  localparam int PMCV_CT_NOXOVER = 3;
  localparam int PMCV_CT_RSV2    = 2;
  localparam int PMCV_CT_TXOFF   = 1;
  localparam int PMCV_CT_RSV0    = 0;
  // writable bits of the control register: 14,13,12,11,9,8,5,4,3,1
  // restart (9) and loopback (14) must be in here or a write can never set them
  localparam logic [15:0] PMCV_CT_WMASK   = 16'h7b3a;
  // control value after reset
  localparam logic [15:0] PMCV_CT_RESET   = 16'h3120;

  // steering bundle to the port-2 phy
  typedef struct packed {
    logic farLoop;
    logic force100;
    logic anEnable;
    logic powerDown;
    logic anRestart;
    logic fullDuplex;
    logic xoverAlgo;
    logic forceCross;
    logic xoverOff;
    logic txDisable;
  } pmcv_phy_ctl_s;
endpackage
`default_nettype wire

// ---- design/pmcv_sync.sv ----
// two-flop synchroniser for a bus of levels
`default_nettype none
module pmcv_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  // all state in one packed struct
  typedef struct packed {
    logic [WIDTH-1:0] stage1;  // first flop, read only by stage2
    logic [WIDTH-1:0] stage2;  // settled copy
  } pmcv_sync_s;

  pmcv_sync_s state;       // registered state
  pmcv_sync_s next_state;  // next value

  // shift the bus one stage per edge
  always_comb begin
    next_state.stage1 = asyncIn;
    next_state.stage2 = state.stage1;
  end

  // registers, cleared on reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign syncOut = state.stage2;
endmodule
`default_nettype wire

// ---- bench/pmcv_phy_model.sv ----
// far-side phy stand-in: takes a restart request promptly or late
`default_nettype none
module pmcv_phy_model (
  input  wire logic clk,         // system clock
  input  wire logic restartReq,  // restart request from control
  input  wire logic slow,        // 1 = take restart late
  output logic      restartDone  // one-cycle restart taken pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] age = 3'h0;        // cycles the request has waited
  initial restartDone = 1'b0;
  // pulse once per request; late mode makes the bit readable for a while
  always @(posedge clk) begin
    age <= (restartReq && !restartDone) ? age + 3'h1 : 3'h0;
    restartDone <= restartReq && !restartDone && age >= (slow ? 3'h3 : 3'h0);
  end
endmodule
`default_nettype wire

// ---- bench/pmcv_phy_mii_control_view_chk.sv ----
// checker: port-level assertions for the phy control view registers
`default_nettype none
module pmcv_phy_mii_control_view_chk (
  input wire logic                    clk,
  input wire logic                    reset,
  input wire logic [11:0]             regAddr,
  input wire logic [15:0]             regWrData,
  input wire logic                    regWrite,
  input wire logic                    regRead,
  input wire logic [15:0]             regRdData,
  input wire logic                    anRestartDone,
  input wire pmcv_pkg::pmcv_phy_ctl_s phyCtl,
  input wire logic                    loopPort1Pairs,
  input wire logic                    port2Speed100,
  input wire logic                    port2FullDuplex,
  input wire logic                    port2TxEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // write or read aimed at the control word
  wire logic wrCtl = regWrite && regAddr == pmcv_pkg::PMCV_OFS_CONTROL;
  wire logic rdCtl = regRead && regAddr == pmcv_pkg::PMCV_OFS_CONTROL;
  // restart steps: software request, then phy takes it
  sequence sAsk; wrCtl && regWrData[9]; endsequence
  sequence sTaken; anRestartDone && !(wrCtl && regWrData[9]); endsequence
  AST_MODE: assert property (wrCtl |=> {port2Speed100, phyCtl.anEnable, port2FullDuplex} ==
    {$past(regWrData[13]), $past(regWrData[12]), $past(regWrData[8])}) else $error("mode bits");
  AST_LOOP: assert property (wrCtl |=> loopPort1Pairs == $past(regWrData[14])
    && phyCtl.farLoop == loopPort1Pairs) else $error("loopback bit");
  AST_XOVER: assert property (wrCtl |=> {phyCtl.xoverAlgo, phyCtl.forceCross,
    phyCtl.xoverOff} == $past(regWrData[5:3])) else $error("crossover bits");
  AST_TXEN: assert property (wrCtl |=> port2TxEnable ==
    !($past(regWrData[1]) || $past(regWrData[11]))) else $error("transmit enable");
  AST_RESTART: assert property (sAsk |=> phyCtl.anRestart) else $error("restart not set");
  AST_SELFCLR: assert property (sTaken |=> !phyCtl.anRestart) else $error("restart stuck");
  AST_PDOWN: assert property (wrCtl |=> {phyCtl.powerDown, phyCtl.txDisable} ==
    {$past(regWrData[11]), $past(regWrData[1])}) else $error("power down or transmit off");
  AST_HOLD: assert property (!wrCtl |=> $stable({loopPort1Pairs, port2Speed100,
    port2FullDuplex, port2TxEnable})) else $error("outputs moved without write");
  AST_RSVZERO: assert property (rdCtl |=> (regRdData & 16'h84c5) == 16'h0000)
    else $error("reserved control bits");
  AST_PARTNER: assert property (regRead && regAddr == pmcv_pkg::PMCV_OFS_PARTNER |=>
    regRdData[4:0] == 5'h01 && regRdData[15:11] == 5'h00 && !regRdData[9]) else $error("partner");
endmodule
// attach beside every instance of the top
bind pmcv_phy_mii_control_view pmcv_phy_mii_control_view_chk chk_u (.clk(clk), .reset(reset),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .anRestartDone(anRestartDone), .phyCtl(phyCtl),
  .loopPort1Pairs(loopPort1Pairs), .port2Speed100(port2Speed100),
  .port2FullDuplex(port2FullDuplex), .port2TxEnable(port2TxEnable));
`default_nettype wire

// ---- bench/pmcv_phy_mii_control_view_bench.sv ----
// bench: register tasks and sequenced checks for the phy control view
`default_nettype none
module pmcv_phy_mii_control_view_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] PA = pmcv_pkg::PMCV_OFS_PARTNER;
  localparam logic [11:0] CT = pmcv_pkg::PMCV_OFS_CONTROL;
  logic                    clk, reset, regWrite, regRead, slow, done, loop, spd, fdx, txe;
  logic [11:0]             regAddr;
  logic [15:0]             regWrData, regRdData;
  logic [4:0]              stat;      // port-1 status seen from the line
  pmcv_pkg::pmcv_phy_ctl_s phyCtl;
  int                      fails, n_checks;
  logic [4:0]              pats [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f};
  pmcv_phy_mii_control_view dut_u (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .port1StatusRaw(stat), .anRestartDone(done), .phyCtl(phyCtl), .loopPort1Pairs(loop),
    .port2Speed100(spd), .port2FullDuplex(fdx), .port2TxEnable(txe));
  pmcv_phy_model phy_u (.clk(clk), .restartReq(phyCtl.anRestart), .slow(slow),
    .restartDone(done));
  // 25 MHz clock
  always #20 clk = ~clk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one-cycle strobes; a gap cycle keeps strobes from being set twice at one edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdData, e);
    @(posedge clk);
  endtask
  // outputs packed as loop, speed, duplex, transmit enable
  task automatic ot(input logic [3:0] e);
    #1 chk({12'h000, loop, spd, fdx, txe}, {12'h000, e});
  endtask
  task automatic print_verdict;
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog well past the roughly 90 cycles the sequence needs
  initial begin
    #50000;
    fails++;
    print_verdict;
  end
  initial begin
    {clk, reset, regWrite, regRead, slow, fails, n_checks} = '0;
    reset = 1'b1;
    regAddr = 12'h000;
    regWrData = 16'h0000;
    stat = 5'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(CT, 16'h3120);
    ot(4'h7);
    // each status bit alone, then all; sync plus capture needs 3 edges
    foreach (pats[i]) begin
      stat <= pats[i];
      repeat (4) @(posedge clk);
      rd(PA, {5'h00, pats[i][4], 1'b0, pats[i][3:0], 5'h01});
    end
    wr(PA, 16'hffff);
    rd(PA, 16'h05e1);
    wr(12'h05a, 16'hffff);
    rd(12'h05a, 16'h0000);
    rd(CT, 16'h3120);
    slow <= 1'b1;
    wr(CT, 16'hffff);
    rd(CT, 16'h7b3a);
    ot(4'he);
    repeat (6) @(posedge clk);
    rd(CT, 16'h793a);
    slow <= 1'b0;
    wr(CT, 16'h4000);
    rd(CT, 16'h4000);
    ot(4'h9);
    wr(CT, 16'h0800);
    ot(4'h0);
    wr(CT, 16'h0002);
    ot(4'h0);
    wr(CT, 16'h1200);
    repeat (3) @(posedge clk);
    rd(CT, 16'h1000);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    rd(CT, 16'h3120);
    print_verdict;
  end
endmodule
`default_nettype wire
